/* rtl/tccim_cmp_chan.sv */
// One compare channel: equality test and toggled waveform output
`timescale 1ns/1ps
module tccim_cmp_chan
  import tccim_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Channel link
  tccim_cmp_if.chan cif
);
  import tccim_pkg::*;

  logic wave_r;

  // Match is checked every cycle, masked after a counter write
  assign cif.hit = (cif.count == cif.value) && !cif.block;

  // Waveform pin toggles on each accepted match
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wave_r <= 1'b0;
    else if (cif.hit && cif.toggle_en)
      wave_r <= ~wave_r;
  end

  assign cif.wave = wave_r;
endmodule

/* rtl/tccim_cmp_if.sv */
// Signals between the top and one compare channel
`timescale 1ns/1ps
interface tccim_cmp_if;
  import tccim_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] value;
  logic             block;
  logic             toggle_en;
  logic             hit;
  logic             wave;
  modport chan (input count, input value, input block, input toggle_en, output hit, output wave);
  modport top  (output count, output value, output block, output toggle_en, input hit, input wave);
endinterface

/* rtl/tccim_pkg.sv */
// Shared constants for the timer capture/compare and interrupt mask block
package tccim_pkg;
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;

  // Register offsets, low byte at base and high byte at base plus one
  localparam logic [ADDR_W-1:0] OFS_MASK1   = 12'h06f;
  localparam logic [ADDR_W-1:0] OFS_MASK3   = 12'h071;
  localparam logic [ADDR_W-1:0] OFS_MASK4   = 12'h072;
  localparam logic [ADDR_W-1:0] OFS_FLAG4   = 12'h039;
  localparam logic [ADDR_W-1:0] OFS_CAPT_L  = 12'h0a6;
  localparam logic [ADDR_W-1:0] OFS_CMPA_L  = 12'h9a8;
  localparam logic [ADDR_W-1:0] OFS_CMPB_L  = 12'h0aa;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_HI_STEP = 12'h001;

  // Bit positions in mask and flag registers
  localparam int BIT_OVF  = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CAPT = 5;
  localparam logic [DATA_W-1:0] MASK_USED = 8'h27;

  // Control register fields
  localparam int CTL_SRC_CMP  = 0;
  localparam int CTL_EDGE_UP  = 1;
  localparam int CTL_TGL_A    = 2;
  localparam int CTL_TGL_B    = 3;
  localparam logic [DATA_W-1:0] CTRL_USED = 8'h0f;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0]  RST_WORD = 16'h0000;
endpackage

/* rtl/tccim_top.sv */
// Capture, compare, shared high-byte latch and interrupt masks of the timers
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module tccim_top
  import tccim_pkg::*;
#(
  parameter int CW = 16
)
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Register port
  input  wire logic [tccim_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tccim_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output      logic [tccim_pkg::DATA_W-1:0] reg_rdata,
  // Counter side
  input  wire logic [CW-1:0]               timer_count_value,
  input  wire logic                        count_write,
  input  wire logic                        overflow_event,
  input  wire logic                        top_from_capture,
  output      logic [CW-1:0]               top_value,
  // Capture sources
  input  wire logic                        capture_input_pin,
  input  wire logic                        analog_comp_out,
  // Interrupt side
  input  wire logic                        global_irq_enable,
  input  wire logic [tccim_pkg::DATA_W-1:0] timer1_irq_flags,
  input  wire logic [tccim_pkg::DATA_W-1:0] timer3_irq_flags,
  input  wire logic [tccim_pkg::DATA_W-1:0] timer4_irq_ack,
  output      logic [tccim_pkg::DATA_W-1:0] timer1_irq_req,
  output      logic [tccim_pkg::DATA_W-1:0] timer3_irq_req,
  output      logic [tccim_pkg::DATA_W-1:0] timer4_irq_req,
  // Waveform pins
  output      logic                        waveform_out_a,
  output      logic                        waveform_out_b
);
  import tccim_pkg::*;

  // Byte-split access only serves a counter of two bytes; refused at elaboration
  if (CW != CNT_W)
  begin
    $error("tccim_top: CW must equal CNT_W");
  end

  // Registers
  logic [DATA_W-1:0] timer1_irq_enable_mask_r;
  logic [DATA_W-1:0] timer3_irq_enable_mask_r;
  logic [DATA_W-1:0] timer4_irq_enable_mask_r;
  logic [DATA_W-1:0] timer_irq_flag_reg_r;
  logic [DATA_W-1:0] ctrl_r;
  logic [CW-1:0]     capture_value_r;
  logic [CW-1:0]     compare_a_value_r;
  logic [CW-1:0]     compare_b_value_r;
  logic [DATA_W-1:0] hold_hi_r;
  logic [DATA_W-1:0] rdata_r;
  logic              pin_prev_r;
  logic              comp_prev_r;
  logic              block_r;

  // Decoded strobes
  logic wr_mask1;
  logic wr_mask3;
  logic wr_mask4;
  logic wr_flag4;
  logic wr_ctrl;
  logic wr_capt_l;
  logic wr_capt_h;
  logic wr_cmpa_l;
  logic wr_cmpa_h;
  logic wr_cmpb_l;
  logic wr_cmpb_h;
  logic rd_low16;

  // Event terms
  logic              cap_src;
  logic              cap_prev;
  logic              cap_edge;
  logic              cap_event;
  logic              top_reached;
  logic [DATA_W-1:0] flag_set;
  logic [DATA_W-1:0] flag_clr;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] hi_nxt;

  // One link per compare channel
  tccim_cmp_if cmp_a_if ();
  tccim_cmp_if cmp_b_if ();

  // Address decode for writes, high byte lives at base plus one
  assign wr_mask1  = reg_wr && (reg_addr == OFS_MASK1);
  assign wr_mask3  = reg_wr && (reg_addr == OFS_MASK3);
  assign wr_mask4  = reg_wr && (reg_addr == OFS_MASK4);
  assign wr_flag4  = reg_wr && (reg_addr == OFS_FLAG4);
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_capt_l = reg_wr && (reg_addr == OFS_CAPT_L);
  assign wr_capt_h = reg_wr && (reg_addr == OFS_CAPT_L + OFS_HI_STEP);
  assign wr_cmpa_l = reg_wr && (reg_addr == OFS_CMPA_L);
  assign wr_cmpa_h = reg_wr && (reg_addr == OFS_CMPA_L + OFS_HI_STEP);
  assign wr_cmpb_l = reg_wr && (reg_addr == OFS_CMPB_L);
  assign wr_cmpb_h = reg_wr && (reg_addr == OFS_CMPB_L + OFS_HI_STEP);

  // Reading any low byte snapshots its high byte into the latch
  assign rd_low16 = reg_rd && ((reg_addr == OFS_CAPT_L) || (reg_addr == OFS_CMPA_L)
                               || (reg_addr == OFS_CMPB_L));

  // Mask registers keep only the four defined enables
  // Dropping bits at write time keeps every reader in step
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer1_irq_enable_mask_r <= RST_BYTE;
      timer3_irq_enable_mask_r <= RST_BYTE;
      timer4_irq_enable_mask_r <= RST_BYTE;
    end
    else
    begin
      if (wr_mask1)
        timer1_irq_enable_mask_r <= reg_wdata & MASK_USED;
      if (wr_mask3)
        timer3_irq_enable_mask_r <= reg_wdata & MASK_USED;
      if (wr_mask4)
        timer4_irq_enable_mask_r <= reg_wdata & MASK_USED;
    end
  end

  // Capture source, edge and waveform toggle selection
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_r <= RST_BYTE;
    else if (wr_ctrl)
      ctrl_r <= reg_wdata & CTRL_USED;
  end

  // Shared high-byte latch: loaded by high-byte writes and low-byte reads
  always_comb
  begin
    hi_nxt = hold_hi_r;
    if (wr_capt_h || wr_cmpa_h || wr_cmpb_h)
      hi_nxt = reg_wdata;
    else if (rd_low16)
    begin
      if (reg_addr == OFS_CAPT_L)
        hi_nxt = capture_value_r[CW-1:DATA_W];
      else if (reg_addr == OFS_CMPA_L)
        hi_nxt = compare_a_value_r[CW-1:DATA_W];
      else
        hi_nxt = compare_b_value_r[CW-1:DATA_W];
    end
  end

  // One byte serves every word register, so interleaved word accesses disturb each other
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      hold_hi_r <= RST_BYTE;
    else
      hold_hi_r <= hi_nxt;
  end

  // Compare values change as a whole word on the low-byte write
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      compare_a_value_r <= RST_WORD;
      compare_b_value_r <= RST_WORD;
    end
    else
    begin
      if (wr_cmpa_l)
        compare_a_value_r <= {hold_hi_r, reg_wdata};
      if (wr_cmpb_l)
        compare_b_value_r <= {hold_hi_r, reg_wdata};
    end
  end

  // Capture source: pin or comparator, sampled for edge detection
  // Both previous samples are taken every cycle whatever the selection, so both detectors stay primed
  assign cap_src  = ctrl_r[CTL_SRC_CMP] ? analog_comp_out : capture_input_pin;
  assign cap_prev = ctrl_r[CTL_SRC_CMP] ? comp_prev_r : pin_prev_r;
  assign cap_edge = ctrl_r[CTL_EDGE_UP] ? (cap_src && !cap_prev) : (!cap_src && cap_prev);

  // Events are ignored while the register defines TOP, else TOP would move
  assign cap_event   = cap_edge && !top_from_capture;
  assign top_reached = top_from_capture && (timer_count_value == capture_value_r);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_prev_r  <= 1'b0;
      comp_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r  <= capture_input_pin;
      comp_prev_r <= analog_comp_out;
    end
  end

  // Capture register: hardware event wins over a software write
  // A write in an event cycle is lost; the captured count is worth more
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      capture_value_r <= RST_WORD;
    else if (cap_event)
      capture_value_r <= timer_count_value;
    else if (wr_capt_l)
      capture_value_r <= {hold_hi_r, reg_wdata};
  end

  // TOP offered to the counter when its mode asks for it
  // Taken straight from the register, so a new TOP applies at once
  assign top_value = capture_value_r;

  // Counter write masks matches in the following cycle
  // Only that one cycle is masked; later matches count again
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      block_r <= 1'b0;
    else
      block_r <= count_write;
  end

  // Compare channels
  // Both channels see the same count and the same blocking term
  assign cmp_a_if.count     = timer_count_value;
  assign cmp_a_if.value     = compare_a_value_r;
  assign cmp_a_if.block     = block_r;
  assign cmp_a_if.toggle_en = ctrl_r[CTL_TGL_A];
  assign cmp_b_if.count     = timer_count_value;
  assign cmp_b_if.value     = compare_b_value_r;
  assign cmp_b_if.block     = block_r;
  assign cmp_b_if.toggle_en = ctrl_r[CTL_TGL_B];

  // Channel A feeds flag bit 1 and pin A
  tccim_cmp_chan u_cmp_a (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cif     (cmp_a_if.chan)
  );

  // Channel B feeds flag bit 2 and pin B
  tccim_cmp_chan u_cmp_b (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cif     (cmp_b_if.chan)
  );

  // Pins come straight from the channel flip-flops
  assign waveform_out_a = cmp_a_if.wave;
  assign waveform_out_b = cmp_b_if.wave;

  // Flag sources of this timer
  always_comb
  begin
    flag_set           = RST_BYTE;
    flag_set[BIT_OVF]  = overflow_event;
    flag_set[BIT_CMPA] = cmp_a_if.hit;
    flag_set[BIT_CMPB] = cmp_b_if.hit;
    flag_set[BIT_CAPT] = cap_event || top_reached;
  end

  // Clear by written one or by vector execution
  assign flag_clr = (wr_flag4 ? reg_wdata : RST_BYTE) | timer4_irq_ack;

  // Set wins over clear so an event in the clear cycle survives
  // Software that clears a flag must reread it to spot such an event
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      timer_irq_flag_reg_r <= RST_BYTE;
    else
      timer_irq_flag_reg_r <= ((timer_irq_flag_reg_r & ~flag_clr) | flag_set) & MASK_USED;
  end

  // Requests need source enable, global enable and flag
  assign timer1_irq_req = global_irq_enable ? (timer1_irq_enable_mask_r & timer1_irq_flags)
                                            : RST_BYTE;
  assign timer3_irq_req = global_irq_enable ? (timer3_irq_enable_mask_r & timer3_irq_flags)
                                            : RST_BYTE;
  assign timer4_irq_req = global_irq_enable ? (timer4_irq_enable_mask_r & timer_irq_flag_reg_r)
                                            : RST_BYTE;

  // Read mux; high bytes come from the latch, unmapped reads give zero
  // Only low-byte reads have a side effect: they load the shared latch
  always_comb
  begin
    rdata_nxt = RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_MASK1:                rdata_nxt = timer1_irq_enable_mask_r;
        OFS_MASK3:                rdata_nxt = timer3_irq_enable_mask_r;
        OFS_MASK4:                rdata_nxt = timer4_irq_enable_mask_r;
        OFS_FLAG4:                rdata_nxt = timer_irq_flag_reg_r;
        OFS_CTRL:                 rdata_nxt = ctrl_r;
        OFS_CAPT_L:               rdata_nxt = capture_value_r[DATA_W-1:0];
        OFS_CMPA_L:               rdata_nxt = compare_a_value_r[DATA_W-1:0];
        OFS_CMPB_L:               rdata_nxt = compare_b_value_r[DATA_W-1:0];
        OFS_CAPT_L + OFS_HI_STEP: rdata_nxt = hold_hi_r;
        OFS_CMPA_L + OFS_HI_STEP: rdata_nxt = hold_hi_r;
        OFS_CMPB_L + OFS_HI_STEP: rdata_nxt = hold_hi_r;
        default:                  rdata_nxt = RST_BYTE;
      endcase
    end
  end

  // Read data valid one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= RST_BYTE;
    else
      rdata_r <= rdata_nxt;
  end

  // Registered, so the port never shows a decode glitch
  assign reg_rdata = rdata_r;
endmodule

/* tb/tb_top.sv */
// Bench for the capture/compare and interrupt mask block
`timescale 1ns/1ps
module tb_top;
  import tccim_pkg::*;
  logic              sys_clk, rst_b, reg_wr, reg_rd, count_write, overflow_event, take_en;
  logic              capture_input_pin, analog_comp_out, global_irq_enable, top_from_capture;
  logic              waveform_out_a, waveform_out_b;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, timer1_irq_flags, timer3_irq_flags, timer4_irq_ack;
  logic [DATA_W-1:0] timer1_irq_req, timer3_irq_req, timer4_irq_req;
  logic [CNT_W-1:0]  timer_count_value, top_value, v, w;
  logic [DATA_W-1:0] m [3];
  logic [ADDR_W-1:0] mreg [3] = '{OFS_MASK1, OFS_MASK3, OFS_MASK4};
  int                seed, failures, comparisons, cycles;

  tccim_top tccim_top_inst (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_count_value, .count_write, .overflow_event, .top_from_capture, .top_value,
    .capture_input_pin, .analog_comp_out, .global_irq_enable, .timer1_irq_flags, .timer3_irq_flags,
    .timer4_irq_ack, .timer1_irq_req, .timer3_irq_req, .timer4_irq_req, .waveform_out_a, .waveform_out_b);
  tccim_cpu_model tccim_cpu_model_inst (.sys_clk, .rst_b, .take_en, .irq_req(timer4_irq_req),
    .irq_ack(timer4_irq_ack));

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the some 140 cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Request a timer should show, given its mask and flags
  function automatic logic [DATA_W-1:0] expreq(input logic [DATA_W-1:0] mk, input logic [DATA_W-1:0] f);
    return global_irq_enable ? (mk & f) : 8'h00;
  endfunction

  // One-cycle write, then an idle edge so strobes never double up
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, 16'(reg_rdata), 16'(e));
    @(posedge sys_clk);
  endtask

  // High byte first so the low-byte write commits the pair
  task automatic wr16(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] x);
    wr(a + OFS_HI_STEP, x[15:8]);
    wr(a, x[7:0]);
  endtask

  task automatic rd16chk(input string n, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] e);
    rdchk(n, a, e[7:0]);
    rdchk(n, a + OFS_HI_STEP, e[15:8]);
  endtask

  initial
  begin
    seed = 80;
    {reg_wr, reg_rd, count_write, overflow_event, capture_input_pin, analog_comp_out} = '0;
    {global_irq_enable, take_en, top_from_capture, rst_b} = '0;
    {reg_addr, reg_wdata, timer1_irq_flags, timer3_irq_flags, timer_count_value} = '0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // Masks, compares and capture zero out of reset, unmapped place too
    foreach (mreg[i])
      rdchk("mask rst", mreg[i], 8'h00);
    rd16chk("cmp a rst", OFS_CMPA_L, 16'h0000);
    rd16chk("cmp b rst", OFS_CMPB_L, 16'h0000);
    rd16chk("capt rst", OFS_CAPT_L, 16'h0000);
    rdchk("unmapped", 12'h5f0, 8'h00);
    // Random mask bytes; unused bits must drop out
    foreach (mreg[i])
    begin
      d = 8'($random(seed));
      m[i] = d & MASK_USED;
      wr(mreg[i], d);
      rdchk("mask", mreg[i], m[i]);
    end
    // Global enable and flags gate timers 1 and 3
    repeat (6)
    begin
      global_irq_enable <= 1'($random(seed));
      timer1_irq_flags  <= 8'($random(seed));
      timer3_irq_flags  <= 8'($random(seed));
      @(posedge sys_clk);
      chk("req1", 16'(timer1_irq_req), 16'(expreq(m[0], timer1_irq_flags)));
      chk("req3", 16'(timer3_irq_req), 16'(expreq(m[1], timer3_irq_flags)));
    end
    // Compare pairs, and the shared latch seen from another register
    repeat (3)
    begin
      v = 16'($random(seed));
      w = v + 16'h0001;
      wr16(OFS_CMPA_L, v);
      wr16(OFS_CMPB_L, w);
      rd16chk("cmp a", OFS_CMPA_L, v);
      rd16chk("cmp b", OFS_CMPB_L, w);
      rdchk("cmp a lo", OFS_CMPA_L, v[7:0]);
      rdchk("latch", OFS_CMPB_L + OFS_HI_STEP, v[15:8]);
    end
    // Back-to-back matches on A then B
    wr(OFS_MASK4, 8'h27);
    wr(OFS_CTRL, 8'h0e);
    wr(OFS_FLAG4, 8'h27);
    global_irq_enable <= 1'b1;
    timer_count_value <= v;
    @(posedge sys_clk);
    timer_count_value <= w;
    #1;
    chk("flag a", 16'(timer4_irq_req), 16'h0002);
    chk("wave a", 16'(waveform_out_a), 16'h0001);
    @(posedge sys_clk);
    timer_count_value <= v + 16'h4000;
    #1;
    chk("flag b", 16'(timer4_irq_req), 16'h0006);
    chk("wave b", 16'(waveform_out_b), 16'h0001);
    // Write-one clears A, the vector clears B
    @(posedge sys_clk);
    wr(OFS_FLAG4, 8'h02);
    chk("w1c", 16'(timer4_irq_req), 16'h0004);
    take_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    take_en     <= 1'b0;
    count_write <= 1'b1;
    #1;
    chk("ack", 16'(timer4_irq_req), 16'h0000);
    // Match right after a counter write is blocked
    @(posedge sys_clk);
    count_write       <= 1'b0;
    timer_count_value <= v;
    @(posedge sys_clk);
    timer_count_value <= v + 16'h4000;
    overflow_event    <= 1'b1;
    @(posedge sys_clk);
    overflow_event <= 1'b0;
    #1;
    chk("blocked", 16'(timer4_irq_req), 16'h0001);
    chk("wave hold", 16'(waveform_out_a), 16'h0001);
    // Rising pin edge captures the live count
    @(posedge sys_clk);
    timer_count_value <= w ^ 16'h00ff;
    capture_input_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("top", top_value, w ^ 16'h00ff);
    chk("capt flag", 16'(timer4_irq_req), 16'h0021);
    @(posedge sys_clk);
    rd16chk("capt", OFS_CAPT_L, w ^ 16'h00ff);
    // Comparator on its falling edge; a falling pin is then ignored
    capture_input_pin <= 1'b0;
    analog_comp_out   <= 1'b1;
    wr(OFS_CTRL, 8'h0d);
    timer_count_value <= v + 16'h2000;
    analog_comp_out   <= 1'b0;
    capture_input_pin <= 1'b1;
    @(posedge sys_clk);
    capture_input_pin <= 1'b0;
    timer_count_value <= v + 16'h3000;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("comp capt", top_value, v + 16'h2000);
    // Capture register as TOP: edges ignored, reaching TOP flags
    @(posedge sys_clk);
    analog_comp_out <= 1'b1;
    wr(OFS_FLAG4, 8'h20);
    top_from_capture  <= 1'b1;
    analog_comp_out   <= 1'b0;
    timer_count_value <= v + 16'h5000;
    @(posedge sys_clk);
    timer_count_value <= v + 16'h2000;
    #1;
    chk("top edge", top_value, v + 16'h2000);
    chk("top wait", 16'(timer4_irq_req), 16'h0001);
    @(posedge sys_clk);
    #1;
    chk("top hit", 16'(timer4_irq_req), 16'h0021);
    // Vector clears overflow; the standing TOP match keeps its flag set
    @(posedge sys_clk);
    take_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("vec", 16'(timer4_irq_req), 16'h0020);
    stop_test();
  end
endmodule

bind tccim_top tccim_chk #(.CW(CW)) tccim_chk_inst (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .count_write, .overflow_event, .top_value, .capture_input_pin, .analog_comp_out, .global_irq_enable,
  .timer1_irq_flags, .timer1_irq_req, .timer3_irq_req, .timer4_irq_req, .timer4_irq_ack, .waveform_out_a,
  .waveform_out_b);

/* tb/tccim_chk.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps
module tccim_chk
  import tccim_pkg::*;
#(
  parameter int CW = 16
)
(
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  // Register port
  input wire logic [tccim_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [tccim_pkg::DATA_W-1:0] reg_rdata,
  // Counter and capture side
  input wire logic                         count_write,
  input wire logic                         overflow_event,
  input wire logic [CW-1:0]                top_value,
  input wire logic                         capture_input_pin,
  input wire logic                         analog_comp_out,
  // Interrupt side
  input wire logic                         global_irq_enable,
  input wire logic [tccim_pkg::DATA_W-1:0] timer1_irq_flags,
  input wire logic [tccim_pkg::DATA_W-1:0] timer1_irq_req,
  input wire logic [tccim_pkg::DATA_W-1:0] timer3_irq_req,
  input wire logic [tccim_pkg::DATA_W-1:0] timer4_irq_req,
  input wire logic [tccim_pkg::DATA_W-1:0] timer4_irq_ack,
  // Waveform pins
  input wire logic                         waveform_out_a,
  input wire logic                         waveform_out_b
);
  import tccim_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Read of any mask register
  sequence s_mask_rd;
    reg_rd && (reg_addr == OFS_MASK1 || reg_addr == OFS_MASK3 || reg_addr == OFS_MASK4);
  endsequence
  // Counter write followed by the cycle it blocks
  sequence s_cnt_wr;
    count_write ##1 1'b1;
  endsequence
  // Two cycles clear of reset, sources quiet and no register write
  sequence s_src_quiet;
    $past(rst_b, 2) && $stable(capture_input_pin) && $stable(analog_comp_out) && !reg_wr;
  endsequence

  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_MASK_UNUSED: assert property (s_mask_rd |=> (reg_rdata & 8'hd8) == 8'h00)
    else $error("unused mask bits read nonzero");
  AST_GIE_OFF: assert property (!global_irq_enable |-> !(|{timer1_irq_req, timer3_irq_req, timer4_irq_req}))
    else $error("request while globally disabled");
  AST_T1_GATE: assert property ((timer1_irq_req & ~(timer1_irq_flags & MASK_USED)) == 8'h00)
    else $error("timer1 request without flag");
  AST_ACK_CLR: assert property (timer4_irq_ack[0] && !overflow_event |=> !timer4_irq_req[0])
    else $error("overflow flag survived its vector");
  // Guard of two cycles keeps the edge detector's reset sample out
  AST_TOP_HOLD: assert property (s_src_quiet |=> $stable(top_value))
    else $error("capture changed without event");
  AST_WAVE_A: assert property ($changed(waveform_out_a) |-> !$past(count_write, 2))
    else $error("pin A toggled on blocked match");
  AST_WAVE_B: assert property (s_cnt_wr |=> $stable(waveform_out_b))
    else $error("pin B toggled on blocked match");
endmodule

/* tb/tccim_cpu_model.sv */
// CPU core stand-in that executes timer 4 interrupt vectors
`timescale 1ns/1ps
module tccim_cpu_model
  import tccim_pkg::*;
(
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  // Vector side
  input  wire logic                         take_en,
  input  wire logic [tccim_pkg::DATA_W-1:0] irq_req,
  output      logic [tccim_pkg::DATA_W-1:0] irq_ack
);
  import tccim_pkg::*;
  // Lowest pending vector first; dead cycle lets the flag drop before the next
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      irq_ack <= 8'h00;
    else if (take_en && irq_ack == 8'h00)
      irq_ack <= irq_req & (~irq_req + 8'h01);
    else
      irq_ack <= 8'h00;
endmodule
